// ---- include/spfs_pkg.sv ----
package spfs_pkg;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int N_CONV_ONE = 4;
    localparam int N_CONV_TWO = 7;
    localparam int N_ANALOG   = 11;
    localparam int N_SHARED   = 6;
    localparam int N_PULSE    = 3;
    localparam int N_TRIG     = 3;
    localparam int FEN_W      = 8;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONV_ONE_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONV_TWO_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ANA_DATA     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ANA_DIR      = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_SHR_DATA     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SHR_DIR      = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FUNC_EN      = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_ANA_LEVEL    = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_SHR_LEVEL    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_PORT_MODE    = 8'h24;

    // ---------------------------------------------------------------
    // Function enable fields
    // ---------------------------------------------------------------
    localparam int FEN_PULSE_LSB = 0;
    localparam int FEN_IRQ4_BIT  = 3;
    localparam int FEN_IRQ5_BIT  = 4;
    localparam int FEN_TRIG_LSB  = 5;

    // Shared pin positions
    localparam int PIN_IRQ4     = 0;
    localparam int PIN_PULSE2   = 1;
    localparam int PIN_IRQ5     = 2;
    localparam int PIN_TRIG_LSB = 3;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [N_CONV_ONE-1:0] RST_CONV_ONE = 4'h0;
    localparam logic [N_CONV_TWO-1:0] RST_CONV_TWO = 7'h00;
    localparam logic [N_ANALOG-1:0]   RST_ANA      = 11'h000;
    localparam logic [N_SHARED-1:0]   RST_SHR      = 6'h00;
    localparam logic [FEN_W-1:0]      RST_FEN      = 8'h00;

endpackage : spfs_pkg

// ---- rtl/spfs_sync.sv ----
`timescale 1ns/10ps
// -------------------------------------------------------------------
// Two-stage synchroniser for pin levels
// -------------------------------------------------------------------
module spfs_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } spfs_sync_t;

    spfs_sync_t st;
    spfs_sync_t next_st;

    // First stage feeds only the second
    always_comb
    begin
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        // Reset to each pin's idle level, so no false edge follows reset
        if (!reset_n_in)
            st <= '{meta: RST_VAL, stable: RST_VAL};
        else
            st <= next_st;
    end

    assign sync_out = st.stable;

endmodule : spfs_sync

// ---- rtl/spfs_pin_cell.sv ----
`timescale 1ns/10ps
// -------------------------------------------------------------------
// One pin: analog release, function drive or port drive
// -------------------------------------------------------------------
module spfs_pin_cell (
    // Selection
    input  wire logic analog_sel_in,
    input  wire logic fn_drive_in,
    input  wire logic fn_wave_in,
    // Port bit
    input  wire logic port_data_in,
    input  wire logic port_dir_in,
    // Next pin drive
    output logic      pin_out,
    output logic      pin_oe_n_out
);

    // Analog wins so the converter never sees a fighting driver
    always_comb
    begin
        if (analog_sel_in)
        begin
            pin_out      = 1'b0;
            pin_oe_n_out = 1'b1;
        end
        else if (fn_drive_in)
        begin
            pin_out      = fn_wave_in;
            pin_oe_n_out = 1'b0;
        end
        else
        begin
            pin_out      = port_data_in;
            pin_oe_n_out = ~port_dir_in;
        end
    end

endmodule : spfs_pin_cell

// ---- rtl/spfs_top.sv ----
`timescale 1ns/10ps
// -------------------------------------------------------------------
// Shared pin function select
// -------------------------------------------------------------------
module spfs_top (
    // Clock and reset
    input  wire logic                           clk_in,
    input  wire logic                           reset_n_in,
    // APB slave
    input  wire logic                           psel_in,
    input  wire logic                           penable_in,
    input  wire logic                           pwrite_in,
    input  wire logic [spfs_pkg::ADDR_W-1:0]    paddr_in,
    input  wire logic [spfs_pkg::DATA_W-1:0]    pwdata_in,
    output logic      [spfs_pkg::DATA_W-1:0]    prdata_out,
    output logic                                pready_out,
    output logic                                pslverr_out,
    // Analog-capable pins 0..10
    input  wire logic [spfs_pkg::N_ANALOG-1:0]  an_pin_in,
    output logic      [spfs_pkg::N_ANALOG-1:0]  an_pin_out,
    output logic      [spfs_pkg::N_ANALOG-1:0]  an_pin_oe_n_out,
    // Converter routing
    output logic      [spfs_pkg::N_CONV_ONE-1:0] conv_one_route_out,
    output logic      [spfs_pkg::N_CONV_TWO-1:0] conv_two_route_out,
    // Shared port0 pins 0..5
    input  wire logic [spfs_pkg::N_SHARED-1:0]  shr_pin_in,
    output logic      [spfs_pkg::N_SHARED-1:0]  shr_pin_out,
    output logic      [spfs_pkg::N_SHARED-1:0]  shr_pin_oe_n_out,
    // Pulse generator waveforms
    input  wire logic [spfs_pkg::N_PULSE-1:0]   pulse_wave_in,
    // Peripheral inputs
    output logic                                ext_irq_line_four_out,
    output logic                                ext_irq_line_five_out,
    output logic      [spfs_pkg::N_TRIG-1:0]    reload_trigger_out,
    // Non-maskable request
    input  wire logic                           nmi_pin_n_in,
    output logic                                nmi_req_out
);

    localparam int NA = spfs_pkg::N_ANALOG;
    localparam int NS = spfs_pkg::N_SHARED;
    localparam int N1 = spfs_pkg::N_CONV_ONE;
    localparam int N2 = spfs_pkg::N_CONV_TWO;
    localparam int NP = spfs_pkg::N_PULSE;
    localparam int NT = spfs_pkg::N_TRIG;
    localparam int SW = NA + NS + 1;
    localparam logic [SW-1:0] SYNC_RST = {1'b1, {(NA + NS){1'b0}}}; // Request pin idles high

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [N1-1:0]                   conv_one_sel;
        logic [N2-1:0]                   conv_two_sel;
        logic [NA-1:0]                   ana_data;
        logic [NA-1:0]                   ana_dir;
        logic [NS-1:0]                   shr_data;
        logic [NS-1:0]                   shr_dir;
        logic [spfs_pkg::FEN_W-1:0]      func_en;
        logic                            pready;
        logic                            pslverr;
        logic [spfs_pkg::DATA_W-1:0]     prdata;
        logic [NA-1:0]                   an_out;
        logic [NA-1:0]                   an_oe_n;
        logic [N1-1:0]                   route_one;
        logic [N2-1:0]                   route_two;
        logic [NS-1:0]                   shr_out;
        logic [NS-1:0]                   shr_oe_n;
        logic                            irq_four;
        logic                            irq_five;
        logic [NT-1:0]                   trig;
        logic                            nmi_req;
    } spfs_state_t;

    spfs_state_t st;
    spfs_state_t next_st;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [SW-1:0] sync_lvl;
    logic [NA-1:0] an_lvl;
    logic [NS-1:0] shr_lvl;
    logic          nmi_lvl_n;

    spfs_sync #(
        .WIDTH   (SW),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({nmi_pin_n_in, shr_pin_in, an_pin_in}),
        .sync_out   (sync_lvl)
    );

    assign an_lvl    = sync_lvl[NA-1:0];
    assign shr_lvl   = sync_lvl[NA+NS-1:NA];
    assign nmi_lvl_n = sync_lvl[SW-1];

    // ---------------------------------------------------------------
    // Function enables and per-pin selection
    // ---------------------------------------------------------------
    logic [NP-1:0] pulse_en;
    logic [NT-1:0] trig_en;
    logic          irq4_en;
    logic          irq5_en;
    logic [NA-1:0] ana_sel;
    logic [NS-1:0] drive_en;
    logic [NS-1:0] drive_wave;
    logic [NS-1:0] in_en;
    logic [NS-1:0] port_mode;

    assign pulse_en = st.func_en[spfs_pkg::FEN_PULSE_LSB +: NP];
    assign trig_en  = st.func_en[spfs_pkg::FEN_TRIG_LSB +: NT];
    assign irq4_en  = st.func_en[spfs_pkg::FEN_IRQ4_BIT];
    assign irq5_en  = st.func_en[spfs_pkg::FEN_IRQ5_BIT];
    assign ana_sel  = {st.conv_two_sel, st.conv_one_sel};

    // Only the pulse pins have a driving function
    assign drive_en   = {{(NS-NP){1'b0}}, pulse_en};
    assign drive_wave = {{(NS-NP){1'b0}}, pulse_wave_in};
    // Input-only functions per shared pin
    assign in_en      = {trig_en, irq5_en, 1'b0, irq4_en};
    // Port mode only when no function of the pin is enabled
    assign port_mode  = ~(drive_en | in_en);

    // ---------------------------------------------------------------
    // Pin cells
    // ---------------------------------------------------------------
    logic [NA-1:0] an_next_out;
    logic [NA-1:0] an_next_oe_n;
    logic [NS-1:0] shr_next_out;
    logic [NS-1:0] shr_next_oe_n;

    genvar g;
    generate
        for (g = 0; g < NA + NS; g = g + 1)
        begin : g_pin
            if (g < NA)
            begin : g_ana
                spfs_pin_cell u_cell (
                    .analog_sel_in (ana_sel[g]),
                    .fn_drive_in   (1'b0),
                    .fn_wave_in    (1'b0),
                    .port_data_in  (st.ana_data[g]),
                    .port_dir_in   (st.ana_dir[g]),
                    .pin_out       (an_next_out[g]),
                    .pin_oe_n_out  (an_next_oe_n[g])
                );
            end
            else
            begin : g_shr
                spfs_pin_cell u_cell (
                    .analog_sel_in (1'b0),
                    .fn_drive_in   (drive_en[g-NA]),
                    .fn_wave_in    (drive_wave[g-NA]),
                    .port_data_in  (st.shr_data[g-NA]),
                    .port_dir_in   (st.shr_dir[g-NA]),
                    .pin_out       (shr_next_out[g-NA]),
                    .pin_oe_n_out  (shr_next_oe_n[g-NA])
                );
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Next state: APB and pin outputs
    // ---------------------------------------------------------------
    // One wait state: read data settles while pready is low,
    // writes land only on the completing edge.
    always_comb
    begin
        logic [spfs_pkg::DATA_W-1:0] rd;
        logic                        hit;
        logic                        wr;
        next_st = st;
        rd      = '0;
        hit     = 1'b1;
        wr      = psel_in & penable_in & pwrite_in & st.pready & ~st.pslverr;

        // Address decode
        if (paddr_in == spfs_pkg::OFS_CONV_ONE_SEL)
            rd[N1-1:0] = st.conv_one_sel;
        else if (paddr_in == spfs_pkg::OFS_CONV_TWO_SEL)
            rd[N2-1:0] = st.conv_two_sel;
        else if (paddr_in == spfs_pkg::OFS_ANA_DATA)
            rd[NA-1:0] = st.ana_data;
        else if (paddr_in == spfs_pkg::OFS_ANA_DIR)
            rd[NA-1:0] = st.ana_dir;
        else if (paddr_in == spfs_pkg::OFS_SHR_DATA)
            rd[NS-1:0] = st.shr_data;
        else if (paddr_in == spfs_pkg::OFS_SHR_DIR)
            rd[NS-1:0] = st.shr_dir;
        else if (paddr_in == spfs_pkg::OFS_FUNC_EN)
            rd[spfs_pkg::FEN_W-1:0] = st.func_en;
        else if (paddr_in == spfs_pkg::OFS_ANA_LEVEL)
            rd[NA-1:0] = an_lvl & ~ana_sel;     // Digital input off on analog pins
        else if (paddr_in == spfs_pkg::OFS_SHR_LEVEL)
            rd[NS-1:0] = shr_lvl;
        else if (paddr_in == spfs_pkg::OFS_PORT_MODE)
            rd[NS-1:0] = port_mode;
        else
            hit = 1'b0;

        // Access phase handshake
        if (psel_in & penable_in & ~st.pready)
        begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~hit;
            next_st.prdata  = pwrite_in ? '0 : rd;
        end
        else
        begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end

        // Register writes
        if (wr)
        begin
            if (paddr_in == spfs_pkg::OFS_CONV_ONE_SEL)
                next_st.conv_one_sel = pwdata_in[N1-1:0];
            else if (paddr_in == spfs_pkg::OFS_CONV_TWO_SEL)
                next_st.conv_two_sel = pwdata_in[N2-1:0];
            else if (paddr_in == spfs_pkg::OFS_ANA_DATA)
                next_st.ana_data = pwdata_in[NA-1:0];
            else if (paddr_in == spfs_pkg::OFS_ANA_DIR)
                next_st.ana_dir = pwdata_in[NA-1:0];
            else if (paddr_in == spfs_pkg::OFS_SHR_DATA)
                next_st.shr_data = pwdata_in[NS-1:0];
            else if (paddr_in == spfs_pkg::OFS_SHR_DIR)
                next_st.shr_dir = pwdata_in[NS-1:0];
            else if (paddr_in == spfs_pkg::OFS_FUNC_EN)
                next_st.func_en = pwdata_in[spfs_pkg::FEN_W-1:0];
        end

        // Converter routing
        next_st.route_one = st.conv_one_sel;
        next_st.route_two = st.conv_two_sel;

        // Pin drive
        next_st.an_out   = an_next_out;
        next_st.an_oe_n  = an_next_oe_n;
        next_st.shr_out  = shr_next_out;
        next_st.shr_oe_n = shr_next_oe_n;

        // Inputs see the pin even when the port drives it
        next_st.irq_four = irq4_en & shr_lvl[spfs_pkg::PIN_IRQ4];
        next_st.irq_five = irq5_en & shr_lvl[spfs_pkg::PIN_IRQ5];
        next_st.trig     = trig_en & shr_lvl[spfs_pkg::PIN_TRIG_LSB +: NT];

        // Dedicated request pin, low active
        next_st.nmi_req  = ~nmi_lvl_n;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st              <= '0;
            st.conv_one_sel <= spfs_pkg::RST_CONV_ONE;
            st.conv_two_sel <= spfs_pkg::RST_CONV_TWO;
            st.ana_data     <= spfs_pkg::RST_ANA;
            st.ana_dir      <= spfs_pkg::RST_ANA;
            st.shr_data     <= spfs_pkg::RST_SHR;
            st.shr_dir      <= spfs_pkg::RST_SHR;
            st.func_en      <= spfs_pkg::RST_FEN;
            st.an_oe_n      <= '1;
            st.shr_oe_n     <= '1;
            st.nmi_req      <= 1'b0;
        end
        else
            st <= next_st;
    end

    // Outputs straight from flops
    assign prdata_out            = st.prdata;
    assign pready_out            = st.pready;
    assign pslverr_out           = st.pslverr;
    assign an_pin_out            = st.an_out;
    assign an_pin_oe_n_out       = st.an_oe_n;
    assign conv_one_route_out    = st.route_one;
    assign conv_two_route_out    = st.route_two;
    assign shr_pin_out           = st.shr_out;
    assign shr_pin_oe_n_out      = st.shr_oe_n;
    assign ext_irq_line_four_out = st.irq_four;
    assign ext_irq_line_five_out = st.irq_five;
    assign reload_trigger_out    = st.trig;
    assign nmi_req_out           = st.nmi_req;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_conv_one_route: assert property (##1 conv_one_route_out == $past(st.conv_one_sel))
        else $error("converter one routing wrong");
    a_conv_two_route: assert property (##1 conv_two_route_out == $past(st.conv_two_sel))
        else $error("converter two routing wrong");
    a_analog_quiet: assert property (##1 (~an_pin_oe_n_out & $past(ana_sel)) == '0)
        else $error("analog pin driven");
    a_port_drive_ana: assert property (##1 ((an_pin_oe_n_out ^ ~$past(st.ana_dir))
        & ~$past(ana_sel)) == '0)
        else $error("port pin drive mismatch");
    a_pulse_drive_on: assert property (pulse_en[0] |=> !shr_pin_oe_n_out[0]
        && shr_pin_out[0] == $past(pulse_wave_in[0]))
        else $error("pulse one not driven");
    a_pulse_two_port: assert property (!pulse_en[1] |=>
        shr_pin_oe_n_out[1] == !$past(st.shr_dir[1])
        && shr_pin_out[1] == $past(st.shr_data[1]))
        else $error("pulse two pin not port");
    // Port mode is judged in the enable cycle; a write may change it at the next edge
    a_shared_port: assert property (!pulse_en[2] && !irq5_en |-> port_mode[2] ##1
        (shr_pin_oe_n_out[2] == !$past(st.shr_dir[2]) && !ext_irq_line_five_out))
        else $error("irq five pin not port");
    a_trig_port: assert property (!trig_en[0] |=> !reload_trigger_out[0]
        && shr_pin_oe_n_out[3] == !$past(st.shr_dir[3]))
        else $error("trigger pin not port");
    a_nmi_path: assert property ($fell(nmi_pin_n_in) ##1 !nmi_pin_n_in [*2]
        |=> nmi_req_out)
        else $error("nmi request missing");
    a_input_pass: assert property (irq4_en && shr_lvl[0] && !shr_pin_oe_n_out[0]
        |=> ext_irq_line_four_out)
        else $error("driven pin lost to irq");

    c_analog_sel: cover property (conv_two_route_out != '0);
    c_pulse_out: cover property (pulse_en != '0 ##1 shr_pin_oe_n_out[0] == 1'b0);
    c_apb_err: cover property (pready_out && pslverr_out);

endmodule : spfs_top

// ---- verification/spfs_board.sv ----
`timescale 1ns/10ps
// -------------------------------------------------------------------
// Board side: resolves each pin from device drive and board level
// -------------------------------------------------------------------
module spfs_board (
    // Device drive
    input  wire logic [spfs_pkg::N_ANALOG-1:0] an_drv_in,
    input  wire logic [spfs_pkg::N_ANALOG-1:0] an_oe_n_in,
    input  wire logic [spfs_pkg::N_SHARED-1:0] shr_drv_in,
    input  wire logic [spfs_pkg::N_SHARED-1:0] shr_oe_n_in,
    // Board levels
    input  wire logic [spfs_pkg::N_ANALOG-1:0] an_ext_in,
    input  wire logic [spfs_pkg::N_SHARED-1:0] shr_ext_in,
    // Resolved wires
    output logic      [spfs_pkg::N_ANALOG-1:0] an_lvl_out,
    output logic      [spfs_pkg::N_SHARED-1:0] shr_lvl_out
);
    // Device wins where it drives, so a driven input pin reads back the port or function value the device drives
    always_comb
    begin
        an_lvl_out  = (an_drv_in & ~an_oe_n_in) | (an_ext_in & an_oe_n_in);
        shr_lvl_out = (shr_drv_in & ~shr_oe_n_in) | (shr_ext_in & shr_oe_n_in);
    end
endmodule : spfs_board

// ---- verification/tb.sv ----
`timescale 1ns/10ps
// -------------------------------------------------------------------
// Self-checking bench for the shared pin selector
// -------------------------------------------------------------------
module tb;
    logic        clk_in;
    logic        reset_n_in = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq4, irq5, nmi_req;
    logic [10:0] an_drv, an_oe_n, an_lvl;
    logic [10:0] an_ext = 11'h000;
    logic [5:0]  shr_drv, shr_oe_n, shr_lvl;
    logic [5:0]  shr_ext = 6'h00;
    logic [3:0]  conv1;
    logic [6:0]  conv2;
    logic [2:0]  wave = 3'h0;
    logic [2:0]  trig;
    logic        nmi_n = 1'b1;
    logic [31:0] r;
    logic        e;
    int          error_cnt = 0;
    int          tests_run = 0;

    // Design and board
    spfs_top i_spfs_top (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .an_pin_in(an_lvl), .an_pin_out(an_drv), .an_pin_oe_n_out(an_oe_n),
        .conv_one_route_out(conv1), .conv_two_route_out(conv2), .shr_pin_in(shr_lvl),
        .shr_pin_out(shr_drv), .shr_pin_oe_n_out(shr_oe_n), .pulse_wave_in(wave),
        .ext_irq_line_four_out(irq4), .ext_irq_line_five_out(irq5),
        .reload_trigger_out(trig), .nmi_pin_n_in(nmi_n), .nmi_req_out(nmi_req));
    spfs_board i_spfs_board (.an_drv_in(an_drv), .an_oe_n_in(an_oe_n), .shr_drv_in(shr_drv),
        .shr_oe_n_in(shr_oe_n), .an_ext_in(an_ext), .shr_ext_in(shr_ext),
        .an_lvl_out(an_lvl), .shr_lvl_out(shr_lvl));

    // 50 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    // One APB transfer; waits for pready, only the watchdog ends a hung wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd_data, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_in);
        end
        while (pready !== 1'b1);
        rd_data = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        x;
        apb(1'b1, a, d, q, x);
        // Pins and routes follow one edge after the write; let it pass before any check
        @(posedge clk_in);
    endtask : wr

    // Read and compare the masked bits
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] q;
        logic        z;
        apb(1'b0, a, 32'h0, q, z);
        chk(q & m, x);
    endtask : rd

    task end_sim;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // Watchdog, far beyond the fewer than two hundred cycles the sequence needs
    initial
    begin
        #100us;
        error_cnt++;
        end_sim();
    end

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        // Reset values, then an unmapped address
        for (int a = 0; a <= 24; a += 4)
            rd(8'(a), 32'hffffffff, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk(32'(e), 32'h1);
        // Plain port operation; level register is read-only
        shr_ext <= 6'h3c;
        wr(spfs_pkg::OFS_SHR_DIR, 32'h3f);
        wr(spfs_pkg::OFS_SHR_DATA, 32'h15);
        wr(spfs_pkg::OFS_SHR_LEVEL, 32'hff);
        repeat (3) @(posedge clk_in);
        chk(32'(shr_oe_n), 32'h0);
        chk(32'(shr_drv), 32'h15);
        rd(spfs_pkg::OFS_SHR_LEVEL, 32'h3f, 32'h15);
        // Analog selection releases the pins and routes them
        wr(spfs_pkg::OFS_ANA_DIR, 32'h7ff);
        wr(spfs_pkg::OFS_ANA_DATA, 32'h555);
        wr(spfs_pkg::OFS_CONV_ONE_SEL, 32'hf);
        wr(spfs_pkg::OFS_CONV_TWO_SEL, 32'h7f);
        chk(32'(conv1), 32'hf);
        chk(32'(conv2), 32'h7f);
        chk(32'(an_oe_n), 32'h7ff);
        rd(spfs_pkg::OFS_ANA_LEVEL, 32'h7ff, 32'h0);
        wr(spfs_pkg::OFS_CONV_ONE_SEL, 32'h5);
        wr(spfs_pkg::OFS_CONV_TWO_SEL, 32'h0);
        chk(32'(conv1), 32'h5);
        chk(32'(conv2), 32'h0);
        chk(32'(an_oe_n), 32'h5);
        chk(32'(an_drv & 11'h7fa), 32'h550);
        // Pulse two overrides the port bit while enabled
        wave <= 3'b010;
        wr(spfs_pkg::OFS_FUNC_EN, 32'h02);
        chk(32'(shr_drv), 32'h17);
        wave <= 3'b000;
        repeat (2) @(posedge clk_in);
        chk(32'(shr_drv), 32'h15);
        wave <= 3'b111;
        wr(spfs_pkg::OFS_FUNC_EN, 32'h00);
        chk(32'(shr_drv), 32'h15);
        // Pulse one and interrupt four on one pin; port drivers off first
        shr_ext <= 6'h05;
        wr(spfs_pkg::OFS_SHR_DIR, 32'h0);
        wr(spfs_pkg::OFS_FUNC_EN, 32'h09);
        chk(32'({shr_oe_n[0], shr_drv[0]}), 32'h1);
        wr(spfs_pkg::OFS_FUNC_EN, 32'h08);
        rd(spfs_pkg::OFS_PORT_MODE, 32'h1, 32'h0);
        chk(32'(irq4), 32'h1);
        wr(spfs_pkg::OFS_FUNC_EN, 32'h00);
        rd(spfs_pkg::OFS_PORT_MODE, 32'h1, 32'h1);
        // Trigger inputs and interrupt five, then a deliberate port drive
        shr_ext <= 6'h3c;
        wr(spfs_pkg::OFS_FUNC_EN, 32'hf0);
        repeat (5) @(posedge clk_in);
        chk(32'({irq5, trig}), 32'hf);
        wr(spfs_pkg::OFS_SHR_DATA, 32'h0);
        wr(spfs_pkg::OFS_SHR_DIR, 32'h08);
        repeat (5) @(posedge clk_in);
        chk(32'(trig), 32'h6);
        wr(spfs_pkg::OFS_FUNC_EN, 32'h00);
        repeat (5) @(posedge clk_in);
        chk(32'({shr_oe_n, trig}), 32'h1b8);
        rd(spfs_pkg::OFS_PORT_MODE, 32'h38, 32'h38);
        // Dedicated non-maskable request pin
        nmi_n <= 1'b0;
        repeat (5) @(posedge clk_in);
        chk(32'(nmi_req), 32'h1);
        nmi_n <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk(32'(nmi_req), 32'h0);
        end_sim();
    end
endmodule : tb
